// [common/bfail_cfg.svh]
/*
 Timing counts, event indices and record sizes for the breaker-failure logic.
 Assumes a protection program-cycle tick of 5 ms on a 100 MHz core clock.
*/
`ifndef BFAIL_CFG_SVH
`define BFAIL_CFG_SVH
`define BF_STEP_US 5000
`define BF_CLK_MHZ 100
`define BF_TICK_CYCLES (`BF_STEP_US * `BF_CLK_MHZ)
`define BF_DLY_W 19
`define BF_FAIL_DLY_RST 19'd40
`define BF_RETRIP_DLY_RST 19'd20
`define BF_DLY_MAX 19'd360000
`define BF_NUM_EVENTS 8
`define BF_EV_START 0
`define BF_EV_RETRIP 1
`define BF_EV_FAIL 2
`define BF_EV_BLOCK 3
`define BF_EV_DOMON 4
`define BF_EV_SIGNAL 5
`define BF_EV_PHASE 6
`define BF_EV_RES 7
`define BF_NUM_RECORDS 12
`define BF_TS_W 48
`define BF_CUR_W 16
`define BF_CNT_W 16
`endif

// [common/bfail_pkg.sv]
/*
 Types shared by the breaker-failure logic.
 Assumes bfail_cfg.svh is on the include path.
*/
`include "bfail_cfg.svh"
package bfail_pkg;
    typedef enum logic [1:0] {CRIT_CURRENT, CRIT_CUR_AND_DO, CRIT_CUR_OR_DO, CRIT_DIGITAL} crit_e;
    typedef enum logic [2:0] {ST_NORMAL, ST_START, ST_RETRIP, ST_FAIL_ON, ST_BLOCKED} cond_e;
    typedef logic [`BF_DLY_W-1:0] dly_t;
    typedef logic [`BF_CUR_W-1:0] cur_t;
    typedef logic [`BF_TS_W-1:0] stamp_t;
    typedef logic [2:0] group_t;
    typedef logic [`BF_CNT_W-1:0] cnt_t;
    typedef struct packed {
        stamp_t stamp;
        logic [3:0] event_code;
        cur_t max_phase;
        cur_t residual;
        dly_t to_retrip;
        dly_t to_fail;
        group_t group;
    } record_s;
endpackage

// [hdl/bfail_delay_timer.sv]
/*
 One delay counter advanced on each program-cycle tick while its run input holds.
 Assumes run and tick synchronous to the clock; tick is a one-cycle pulse.
*/
`timescale 1ns/1ps
`include "bfail_cfg.svh"
module bfail_delay_timer #(
    parameter int W = `BF_DLY_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    output logic expired,
    output logic [W-1:0] remain
);
    logic [W-1:0] count;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            count <= '0;
        else if (!run)
            count <= '0;
        else if (tick && count < limit)
            count <= count + 1'b1;
    end

    assign expired = run && (count >= limit);
    assign remain = (count >= limit) ? '0 : limit - count;
endmodule

// [hdl/bfail_record_store.sv]
/*
 Rolling store of the latest operation records; the oldest is overwritten when full.
 Assumes the writer pulses wr_en for one cycle per record.
*/
`timescale 1ns/1ps
`include "bfail_cfg.svh"
module bfail_record_store
    import bfail_pkg::*;
#(
    parameter int DEPTH = `BF_NUM_RECORDS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input bfail_pkg::record_s wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output bfail_pkg::record_s rd_data,
    output logic [$clog2(DEPTH+1)-1:0] fill
);
    localparam int AW = $clog2(DEPTH);
    record_s mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] oldest;
    logic [AW:0] idx_sum;

    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_ptr] <= wr_data;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            fill <= '0;
        end
        else if (wr_en)
        begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (fill != ($bits(fill))'(DEPTH))
                fill <= fill + 1'b1;
        end
    end

    // Index 0 is the oldest record held
    assign oldest = (fill == ($bits(fill))'(DEPTH)) ? wr_ptr : '0;
    assign idx_sum = {1'b0, oldest} + {1'b0, rd_idx};
    assign rd_data = mem[(idx_sum >= (AW+1)'(DEPTH)) ? AW'(idx_sum - (AW+1)'(DEPTH))
                                                      : idx_sum[AW-1:0]];
endmodule

// [hdl/bfail_top.sv]
/*
 Breaker-failure supervision: start criteria, retrip and failure timers, events,
 counters and the rolling record store.
 Assumes inputs synchronous to CORE_CLK and a free-running time stamp input.
*/
// How it works
// - Current criterion: phase or residual pick-up starts timing, trip contact ignored
// - Current criterion: failure output after pick-up lasts the whole failure delay
// - Current criterion: timer clears at once when all currents drop
// - Current-and-contact: timer halted until supervised trip contact energises
// - Current-and-contact: either dropping resets timer; both must last the delay
// - Current-or-contact: either current or trip signal starts timing
// - Current-or-contact: pick-up holds while either holds; failure after delay
// - Current-or-contact: reset only when current low and trip signal gone
// - Digital criterion: digital input starts timer, optional current and contact checks
// - Digital criterion: failure command when timer lasts the failure delay
// - Separate retrip and failure outputs with their own delays
// - ON and OFF events for eight status conditions
// - Each event may report its ON edge, OFF edge or both; only ON edges are stored as records
// - Every recorded event carries a time stamp
// - Resettable counters for retrip, failure, start and blocked
// - Rolling store of twelve records, oldest overwritten
// - Record holds time, event, currents, remaining times and setting group
// - Block active at pick-up gives blocked indication and no action
// - Block after start releases start like pick-up ending
// - Failure delay 0 to 1800 s in 5 ms steps, default 0.200 s
// - Retrip delay in 5 ms steps, default 0.100 s, same pick-up
`timescale 1ns/1ps
`include "bfail_cfg.svh"
module bfail_top
    import bfail_pkg::*;
#(
    parameter int TICK_CYCLES = `BF_TICK_CYCLES
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Pick-up flags and monitored signals
    input wire logic PHASE_PICKUP,
    input wire logic RESIDUAL_PICKUP,
    input wire logic TRIP_CONTACT,
    input wire logic TRIP_DIGITAL_IN,
    input wire logic BLOCK_IN,
    // Configuration
    input bfail_pkg::crit_e CRITERION,
    input wire logic DIG_USE_CURRENT,
    input wire logic DIG_USE_CONTACT,
    input wire logic RETRIP_ENABLE,
    input bfail_pkg::dly_t FAIL_DELAY,
    input bfail_pkg::dly_t RETRIP_DELAY,
    input bfail_pkg::group_t SETTING_GROUP,
    input wire logic [2*`BF_NUM_EVENTS-1:0] EVENT_MASK,
    // Measurement and time
    input bfail_pkg::cur_t MAX_PHASE_CURRENT,
    input bfail_pkg::cur_t RESIDUAL_CURRENT,
    input bfail_pkg::stamp_t TIME_STAMP,
    // Outputs to breakers and status outputs
    output logic BREAKER_FAILURE_OUTPUT,
    output logic RETRIP_OUTPUT,
    output logic START_OUT,
    output logic BLOCKED_OUT,
    output bfail_pkg::cond_e CONDITION,
    // Event stream
    output logic EVENT_VALID,
    output logic [3:0] EVENT_CODE,
    output bfail_pkg::stamp_t EVENT_STAMP,
    // Counters
    input wire logic COUNTER_CLEAR,
    output bfail_pkg::cnt_t RETRIP_COUNT,
    output bfail_pkg::cnt_t FAIL_COUNT,
    output bfail_pkg::cnt_t START_COUNT,
    output bfail_pkg::cnt_t BLOCKED_COUNT,
    // Record read-out
    input wire logic [3:0] RECORD_INDEX,
    output bfail_pkg::record_s RECORD_DATA,
    output logic [3:0] RECORD_FILL
);
    import bfail_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Program-cycle tick
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt;
    logic tick;

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            tick_cnt <= '0;
        else if (tick_cnt == ($bits(tick_cnt))'(TICK_CYCLES - 1))
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 1'b1;
    end
    assign tick = (tick_cnt == ($bits(tick_cnt))'(TICK_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Pick-up per criterion
    logic cur_pick;
    logic pickup;
    logic next_blocked;
    logic run;

    assign cur_pick = PHASE_PICKUP || RESIDUAL_PICKUP;

    always_comb
    begin
        unique case (CRITERION)
            CRIT_CURRENT: pickup = cur_pick;
            CRIT_CUR_AND_DO: pickup = cur_pick && TRIP_CONTACT;
            CRIT_CUR_OR_DO: pickup = cur_pick || TRIP_CONTACT;
            CRIT_DIGITAL: pickup = TRIP_DIGITAL_IN
                && (!DIG_USE_CURRENT || cur_pick)
                && (!DIG_USE_CONTACT || TRIP_CONTACT);
        endcase
    end

    assign next_blocked = pickup && BLOCK_IN;
    assign run = pickup && !BLOCK_IN;

    ////////////////////////////////////////////////////////////////////////////
    // Delay timers
    logic fail_exp;
    logic retrip_exp;
    dly_t fail_remain;
    dly_t retrip_remain;
    dly_t fail_lim;

    assign fail_lim = (FAIL_DELAY > `BF_DLY_MAX) ? `BF_DLY_MAX : FAIL_DELAY;

    bfail_delay_timer #(.W(`BF_DLY_W)) u_fail_timer (
        .clk(CORE_CLK),
        .nrst(NRST),
        .run(run),
        .tick(tick),
        .limit(fail_lim),
        .expired(fail_exp),
        .remain(fail_remain)
    );

    bfail_delay_timer #(.W(`BF_DLY_W)) u_retrip_timer (
        .clk(CORE_CLK),
        .nrst(NRST),
        .run(run && RETRIP_ENABLE),
        .tick(tick),
        .limit(RETRIP_DELAY),
        .expired(retrip_exp),
        .remain(retrip_remain)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    // failure, retrip, start and blocked levels
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            BREAKER_FAILURE_OUTPUT <= 1'b0;
            RETRIP_OUTPUT <= 1'b0;
            START_OUT <= 1'b0;
            BLOCKED_OUT <= 1'b0;
        end
        else
        begin
            BREAKER_FAILURE_OUTPUT <= fail_exp;
            RETRIP_OUTPUT <= retrip_exp;
            START_OUT <= run;
            BLOCKED_OUT <= next_blocked;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            CONDITION <= ST_NORMAL;
        else if (next_blocked)
            CONDITION <= ST_BLOCKED;
        else if (fail_exp)
            CONDITION <= ST_FAIL_ON;
        else if (retrip_exp)
            CONDITION <= ST_RETRIP;
        else if (run)
            CONDITION <= ST_START;
        else
            CONDITION <= ST_NORMAL;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events
    logic [`BF_NUM_EVENTS-1:0] ev_now;
    logic [`BF_NUM_EVENTS-1:0] ev_prev;
    logic [2*`BF_NUM_EVENTS-1:0] ev_edge;
    logic [2*`BF_NUM_EVENTS-1:0] ev_pend;
    logic [2*`BF_NUM_EVENTS-1:0] ev_take;
    logic [3:0] ev_sel;
    logic ev_any;

    assign ev_now[`BF_EV_START] = run;
    assign ev_now[`BF_EV_RETRIP] = retrip_exp;
    assign ev_now[`BF_EV_FAIL] = fail_exp;
    assign ev_now[`BF_EV_BLOCK] = BLOCK_IN;
    assign ev_now[`BF_EV_DOMON] = TRIP_CONTACT;
    assign ev_now[`BF_EV_SIGNAL] = TRIP_DIGITAL_IN;
    assign ev_now[`BF_EV_PHASE] = PHASE_PICKUP;
    assign ev_now[`BF_EV_RES] = RESIDUAL_PICKUP;

    for (genvar g = 0; g < `BF_NUM_EVENTS; g++)
    begin : g_edge
        assign ev_edge[2*g] = ev_now[g] && !ev_prev[g] && EVENT_MASK[2*g];
        assign ev_edge[2*g+1] = !ev_now[g] && ev_prev[g] && EVENT_MASK[2*g+1];
    end

    always_comb
    begin
        ev_sel = '0;
        ev_any = 1'b0;
        ev_take = '0;
        for (int i = 2*`BF_NUM_EVENTS - 1; i >= 0; i--)
        begin
            if (ev_pend[i])
            begin
                ev_sel = 4'(i);
                ev_any = 1'b1;
            end
        end
        if (ev_any)
            ev_take[ev_sel] = 1'b1;
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ev_prev <= '0;
            ev_pend <= '0;
        end
        else
        begin
            ev_prev <= ev_now;
            // New edge wins over the clear of the one being emitted
            ev_pend <= (ev_pend & ~ev_take) | ev_edge;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            EVENT_VALID <= 1'b0;
            EVENT_CODE <= '0;
            EVENT_STAMP <= '0;
        end
        else
        begin
            EVENT_VALID <= ev_any;
            EVENT_CODE <= ev_sel;
            EVENT_STAMP <= TIME_STAMP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counters
    // cumulative counters
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            RETRIP_COUNT <= '0;
            FAIL_COUNT <= '0;
            START_COUNT <= '0;
            BLOCKED_COUNT <= '0;
        end
        else if (COUNTER_CLEAR)
        begin
            RETRIP_COUNT <= '0;
            FAIL_COUNT <= '0;
            START_COUNT <= '0;
            BLOCKED_COUNT <= '0;
        end
        else
        begin
            if (retrip_exp && !ev_prev[`BF_EV_RETRIP])
                RETRIP_COUNT <= RETRIP_COUNT + 1'b1;
            if (fail_exp && !ev_prev[`BF_EV_FAIL])
                FAIL_COUNT <= FAIL_COUNT + 1'b1;
            if (run && !ev_prev[`BF_EV_START])
                START_COUNT <= START_COUNT + 1'b1;
            if (next_blocked && !BLOCKED_OUT)
                BLOCKED_COUNT <= BLOCKED_COUNT + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Records
    record_s rec_in;
    record_s rec_out;
    logic [3:0] fill;
    logic rec_wr;

    assign rec_wr = ev_any && !ev_sel[0];
    assign rec_in = '{stamp: TIME_STAMP, event_code: ev_sel, max_phase: MAX_PHASE_CURRENT,
                      residual: RESIDUAL_CURRENT, to_retrip: retrip_remain,
                      to_fail: fail_remain, group: SETTING_GROUP};

    bfail_record_store #(.DEPTH(`BF_NUM_RECORDS)) u_store (
        .clk(CORE_CLK),
        .nrst(NRST),
        .wr_en(rec_wr),
        .wr_data(rec_in),
        .rd_idx(RECORD_INDEX),
        .rd_data(rec_out),
        .fill(fill)
    );

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            RECORD_DATA <= '0;
            RECORD_FILL <= '0;
        end
        else
        begin
            RECORD_DATA <= rec_out;
            RECORD_FILL <= fill;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_fail_needs_run;
        @(posedge CORE_CLK) disable iff (!NRST) BREAKER_FAILURE_OUTPUT |-> $past(run);
    endproperty
    a_fail_needs_run: assert property (p_fail_needs_run) else $error("failure without pick-up");

    property p_cur_start;
        @(posedge CORE_CLK) disable iff (!NRST)
            (CRITERION == CRIT_CURRENT && cur_pick && !BLOCK_IN) |=> START_OUT;
    endproperty
    a_cur_start: assert property (p_cur_start) else $error("current start missed");

    property p_and_halt;
        @(posedge CORE_CLK) disable iff (!NRST)
            (CRITERION == CRIT_CUR_AND_DO && !TRIP_CONTACT) |=> !START_OUT;
    endproperty
    a_and_halt: assert property (p_and_halt) else $error("timer ran without contact");

    property p_or_start;
        @(posedge CORE_CLK) disable iff (!NRST)
            (CRITERION == CRIT_CUR_OR_DO && TRIP_CONTACT && !BLOCK_IN) |=> START_OUT;
    endproperty
    a_or_start: assert property (p_or_start) else $error("contact start missed");

    property p_block;
        @(posedge CORE_CLK) disable iff (!NRST)
            (pickup && BLOCK_IN) |=> (BLOCKED_OUT && !START_OUT);
    endproperty
    a_block: assert property (p_block) else $error("block not honoured");

    property p_release;
        @(posedge CORE_CLK) disable iff (!NRST)
            !run |=> (!BREAKER_FAILURE_OUTPUT && !RETRIP_OUTPUT);
    endproperty
    a_release: assert property (p_release) else $error("output held after release");

    property p_zero_delay;
        @(posedge CORE_CLK) disable iff (!NRST)
            (run && FAIL_DELAY == '0) |=> BREAKER_FAILURE_OUTPUT;
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

    property p_event_stamp;
        @(posedge CORE_CLK) disable iff (!NRST)
            ev_any |=> (EVENT_VALID && EVENT_STAMP == $past(TIME_STAMP));
    endproperty
    a_event_stamp: assert property (p_event_stamp) else $error("event stamp wrong");

    property p_count_clear;
        @(posedge CORE_CLK) disable iff (!NRST) COUNTER_CLEAR |=> (FAIL_COUNT == '0);
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("counter not cleared");

    c_fail: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(BREAKER_FAILURE_OUTPUT));
    c_retrip: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(RETRIP_OUTPUT));
    c_blocked: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(BLOCKED_OUT));
    c_full: cover property (@(posedge CORE_CLK) disable iff (!NRST) RECORD_FILL == 4'd12);
endmodule

// [verif/breaker_model.sv]
/*
 Upstream feeder breaker and redundant trip coil driven by the block outputs.
 Assumes commands are levels synchronous to clk; contacts open two cycles later.
*/
`timescale 1ns/1ps
module breaker_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Commands from the block
    input wire logic fail_cmd,
    input wire logic retrip_cmd,
    // Breaker states
    output logic feeder_open,
    output logic coil_open
);
    logic fail_d;
    logic retrip_d;
    ////////////////////////////////////////////////////////////////////////////////
    // Contacts follow held commands after mechanical delay
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {fail_d, retrip_d, feeder_open, coil_open} <= 4'h0;
        end
        else
        begin
            {fail_d, retrip_d} <= {fail_cmd, retrip_cmd};
            {feeder_open, coil_open} <= {fail_d & fail_cmd, retrip_d & retrip_cmd};
        end
    end
endmodule

// [verif/bfail_top_bench.sv]
/*
 Self-checking bench for bfail_top, criteria, blocking, counters, events, records.
 Assumes TICK_CYCLES of 4 so delays last under twenty clocks.
*/
`timescale 1ns/1ps
`include "bfail_cfg.svh"
module bfail_top_bench;
    import bfail_pkg::*;
    localparam int T = 4;
    localparam int FD = 4;
    localparam int RD = 2;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic ph = 1'b0, rs = 1'b0, co = 1'b0, dg = 1'b0, blk = 1'b0;
    logic dig_cur = 1'b0, dig_con = 1'b0, clr = 1'b0;
    crit_e crit = CRIT_CURRENT;
    logic [15:0] mask = 16'h0000;
    logic [15:0] seen = 16'h0000;
    logic seen_clr = 1'b0;
    dly_t fdly = 19'(FD);
    logic [3:0] ridx = 4'h0;
    group_t grp = 3'h0;
    cur_t cur_ph = 16'h0000;
    stamp_t ts = '0;
    logic fail_o, retrip_o, start_o, blocked_o, ev_valid, feeder_open;
    cond_e cond;
    logic [3:0] ev_code, fill;
    stamp_t ev_stamp;
    cnt_t c_re, c_fa, c_st, c_bl;
    record_s rec;
    stamp_t ev_st [16];
    int ev_n = 0;
    int miscompares = 0;
    int samples_checked = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, time stamp and event capture
    always #5 core_clk = ~core_clk;
    always @(negedge core_clk) ts <= ts + 48'h1;
    always @(posedge core_clk)
    begin
        if (seen_clr)
            seen <= 16'h0000;
        else if (ev_valid === 1'b1)
        begin
            seen[ev_code] <= 1'b1;
            ev_st[ev_n[3:0]] <= ev_stamp;
            ev_n <= ev_n + 1;
        end
    end
    bfail_top #(.TICK_CYCLES(T)) bfail_top_i (
        .CORE_CLK(core_clk), .NRST(nrst), .PHASE_PICKUP(ph), .RESIDUAL_PICKUP(rs),
        .TRIP_CONTACT(co), .TRIP_DIGITAL_IN(dg), .BLOCK_IN(blk), .CRITERION(crit),
        .DIG_USE_CURRENT(dig_cur), .DIG_USE_CONTACT(dig_con), .RETRIP_ENABLE(1'b1),
        .FAIL_DELAY(fdly), .RETRIP_DELAY(19'(RD)), .SETTING_GROUP(grp),
        .EVENT_MASK(mask), .MAX_PHASE_CURRENT(cur_ph), .RESIDUAL_CURRENT(16'h0042),
        .TIME_STAMP(ts), .BREAKER_FAILURE_OUTPUT(fail_o), .RETRIP_OUTPUT(retrip_o),
        .START_OUT(start_o), .BLOCKED_OUT(blocked_o), .CONDITION(cond),
        .EVENT_VALID(ev_valid), .EVENT_CODE(ev_code), .EVENT_STAMP(ev_stamp),
        .COUNTER_CLEAR(clr), .RETRIP_COUNT(c_re), .FAIL_COUNT(c_fa), .START_COUNT(c_st),
        .BLOCKED_COUNT(c_bl), .RECORD_INDEX(ridx), .RECORD_DATA(rec), .RECORD_FILL(fill)
    );
    breaker_model breaker_model_i (
        .clk(core_clk), .nrst(nrst), .fail_cmd(fail_o), .retrip_cmd(retrip_o),
        .feeder_open(feeder_open), .coil_open()
    );
    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input string name, input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic drive(input crit_e c, input logic [3:0] v);
        @(negedge core_clk);
        crit = c;
        {ph, rs, co, dg} = v;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic fire(input string name, input logic exp);
        int n;
        n = 1;
        cyc(1);
        while (fail_o !== 1'b1 && n < 40)
        begin
            cyc(1);
            n++;
        end
        if (exp)
            check(name, n >= (FD - 1) * T && n <= (FD + 1) * T + 3, 1'b1);
        else
            check(name, fail_o, 1'b0);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        miscompares++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        stamp_t t0;
        cyc(6);
        @(negedge core_clk);
        nrst = 1'b1;
        drive(CRIT_CURRENT, 4'b0010);
        fire("cur_contact", 1'b0);
        drive(CRIT_CURRENT, 4'b1000);
        fire("cur_phase", 1'b1);
        check("start", start_o, 1'b1);
        check("retrip", retrip_o, 1'b1);
        cyc(5);
        check("fail_hold", fail_o, 1'b1);
        check("feeder", feeder_open, 1'b1);
        drive(CRIT_CURRENT, 4'b0000);
        cyc(2);
        check("fail_drop", fail_o, 1'b0);
        drive(CRIT_CURRENT, 4'b0100);
        fire("cur_res", 1'b1);
        done("current");
        drive(CRIT_CUR_AND_DO, 4'b1000);
        fire("and_cur", 1'b0);
        drive(CRIT_CUR_AND_DO, 4'b1010);
        fire("and_both", 1'b1);
        drive(CRIT_CUR_AND_DO, 4'b1000);
        cyc(2);
        check("and_drop", fail_o, 1'b0);
        drive(CRIT_CUR_AND_DO, 4'b0010);
        fire("and_con", 1'b0);
        done("and");
        drive(CRIT_CUR_OR_DO, 4'b0010);
        fire("or_con", 1'b1);
        drive(CRIT_CUR_OR_DO, 4'b0100);
        cyc(2);
        check("or_swap", fail_o, 1'b1);
        drive(CRIT_CUR_OR_DO, 4'b0000);
        cyc(2);
        check("or_clear", fail_o, 1'b0);
        done("or");
        drive(CRIT_DIGITAL, 4'b1010);
        fire("dig_none", 1'b0);
        drive(CRIT_DIGITAL, 4'b0001);
        fire("dig_in", 1'b1);
        drive(CRIT_DIGITAL, 4'b0000);
        dig_cur = 1'b1;
        drive(CRIT_DIGITAL, 4'b0001);
        fire("dig_no_cur", 1'b0);
        drive(CRIT_DIGITAL, 4'b1001);
        fire("dig_cur", 1'b1);
        drive(CRIT_CURRENT, 4'b0000);
        dig_cur = 1'b0;
        blk = 1'b1;
        done("digital");
        drive(CRIT_CURRENT, 4'b1000);
        cyc(2);
        check("blocked", blocked_o, 1'b1);
        check("no_start", start_o, 1'b0);
        check("cond", cond, ST_BLOCKED);
        fire("blk_fire", 1'b0);
        drive(CRIT_CURRENT, 4'b0000);
        blk = 1'b0;
        drive(CRIT_CURRENT, 4'b1000);
        cyc(3);
        check("start_pre", start_o, 1'b1);
        @(negedge core_clk);
        blk = 1'b1;
        cyc(2);
        check("start_rel", start_o, 1'b0);
        drive(CRIT_CURRENT, 4'b0000);
        blk = 1'b0;
        clr = 1'b1;
        cyc(2);
        check("clr", {c_re, c_fa, c_st, c_bl}, 64'h0);
        @(negedge core_clk);
        clr = 1'b0;
        done("block");
        drive(CRIT_CURRENT, 4'b1000);
        fire("cnt_fire", 1'b1);
        drive(CRIT_CURRENT, 4'b0000);
        blk = 1'b1;
        drive(CRIT_CURRENT, 4'b1000);
        cyc(3);
        drive(CRIT_CURRENT, 4'b0000);
        blk = 1'b0;
        cyc(3);
        check("counts", {c_re, c_fa, c_st, c_bl}, 64'h0001_0001_0001_0001);
        check("fill0", fill, 4'h0);
        done("counters");
        @(negedge core_clk);
        mask = 16'h1000;
        grp = 3'h5;
        cur_ph = 16'h1234;
        for (int i = 0; i < 13; i++)
        begin
            drive(CRIT_CURRENT, 4'b1000);
            @(posedge core_clk);
            if (i == 0)
                t0 = ts;
            cyc(4);
            drive(CRIT_CURRENT, 4'b0000);
            cyc(3);
        end
        check("stamp", ev_st[0], t0 + 48'h1);
        check("fill12", fill, 4'hc);
        check("no_off", seen & 16'haaaa, 16'h0000);
        @(negedge core_clk);
        ridx = 4'h0;
        cyc(2);
        check("rec_stamp", rec.stamp, ev_st[1]);
        check("rec_code", rec.event_code, 4'hc);
        check("rec_group", rec.group, 3'h5);
        check("rec_cur", rec.max_phase, 16'h1234);
        check("rec_res", rec.residual, 16'h0042);
        @(negedge core_clk);
        mask = 16'h2000;
        drive(CRIT_CURRENT, 4'b1000);
        cyc(4);
        drive(CRIT_CURRENT, 4'b0000);
        cyc(4);
        check("off_only", seen[13], 1'b1);
        check("fill_keep", fill, 4'hc);
        done("records");
        @(negedge core_clk);
        mask = 16'hffff;
        seen_clr = 1'b1;
        drive(CRIT_CURRENT, 4'b1111);
        seen_clr = 1'b0;
        fire("all_fire", 1'b1);
        drive(CRIT_CURRENT, 4'b0000);
        cyc(3);
        @(negedge core_clk);
        blk = 1'b1;
        drive(CRIT_CURRENT, 4'b1000);
        cyc(3);
        drive(CRIT_CURRENT, 4'b0000);
        blk = 1'b0;
        cyc(12);
        check("all_events", seen, 16'hffff);
        done("events");
        @(negedge core_clk);
        fdly = '0;
        drive(CRIT_CURRENT, 4'b1000);
        cyc(2);
        check("zero_dly", fail_o, 1'b1);
        drive(CRIT_CURRENT, 4'b0000);
        fdly = 19'(FD);
        cyc(2);
        check("zero_drop", fail_o, 1'b0);
        done("zero_delay");
        close_out();
    end
endmodule
